// *** bench/dbl_probe.sv ***
// behavioural model of the debug probe and of the shared data pad
`timescale 1ns/100ps
`default_nettype none
module dbl_probe (
  // link drive toward the device
  output logic swclk_o,
  output logic dio_out_o,
  output logic dio_oe_o,
  // resolved pad level
  output logic pad_o,
  // every other driver of the pad
  input wire logic swd_dio_i,
  input wire logic swd_dio_oe_i,
  input wire logic gpio_dio_i,
  input wire logic gpio_dio_oe_i,
  input wire logic pullup_i,
  input wire logic pulldn_i
);
  logic drv_r; // probe drives the pad
  logic val_r; // probe pad value
  // pad resolves from all enables; an undriven pad without pull shows a changed level
  assign pad_o = swd_dio_oe_i ? swd_dio_i : gpio_dio_oe_i ? gpio_dio_i :
                 drv_r ? val_r : pullup_i ? 1'b1 : pulldn_i ? 1'b0 : !val_r;
  // idle levels at time zero
  initial begin
    swclk_o = 1'b0;
    dio_out_o = 1'b0;
    dio_oe_o = 1'b0;
    drv_r = 1'b0;
    val_r = 1'b0;
  end
  // one frame of n clocks at 15 ns; the clock stands still outside frames
  task automatic frame(input int n, input logic port_drv, input logic [31:0] bits);
    #3;
    for (int i = 0; i < n; i++) begin
      dio_out_o = bits[i];
      dio_oe_o = port_drv;
      drv_r = !port_drv;
      val_r = bits[i];
      #7.5 swclk_o = 1'b1;
      #7.5 swclk_o = 1'b0;
    end
    // release: the port drive no longer shows its last value
    dio_oe_o = 1'b0;
    dio_out_o = !dio_out_o;
    drv_r = 1'b0;
  endtask : frame
endmodule : dbl_probe
`default_nettype wire

// *** bench/test_debug_enable_pin_lock.sv ***
// self-checking bench of the debug enable pin lock
`timescale 1ns/100ps
`default_nettype none
`include "dbl_params.svh"
module test_debug_enable_pin_lock;
  // system side
  logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, core_halt_i;
  logic pin_reset_n_i, debug_enable_pin_n_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  dbl_pkg::dbl_word_t dat_i, dat_o, rd;
  // link and pad
  logic swclk, dio_out, dio_oe, pad, swd_dio_o, swd_dio_oe_o, swd_dio_in_o;
  // pin multiplexer and halt outputs
  logic clk_sel, dio_sel, gpio_clk_o, gpio_clk_oe_o, gpio_dio_o, gpio_dio_oe_o;
  logic wdt_run_o, periph_run_o, lock_o;
  logic [1:0] pullup_o, pulldn_o, timer_run_o;
  logic [31:0] bits;
  int mismatches, cmp_count;

  dbl_lock dbl_lock_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .pin_reset_n_i(pin_reset_n_i), .debug_enable_pin_n_i(debug_enable_pin_n_i),
    .swclk_i(swclk), .pad_dio_i(pad), .swd_dio_out_i(dio_out), .swd_dio_oe_i(dio_oe),
    .swd_dio_o(swd_dio_o), .swd_dio_oe_o(swd_dio_oe_o), .swd_dio_in_o(swd_dio_in_o),
    .clk_debug_sel_o(clk_sel), .dio_debug_sel_o(dio_sel), .gpio_clk_o(gpio_clk_o),
    .gpio_clk_oe_o(gpio_clk_oe_o), .gpio_dio_o(gpio_dio_o), .gpio_dio_oe_o(gpio_dio_oe_o),
    .pullup_o(pullup_o), .pulldn_o(pulldn_o), .core_halt_i(core_halt_i),
    .wdt_run_o(wdt_run_o), .timer_run_o(timer_run_o), .periph_run_o(periph_run_o),
    .debug_lock_status_o(lock_o));

  dbl_probe dbl_probe_inst (.swclk_o(swclk), .dio_out_o(dio_out), .dio_oe_o(dio_oe),
    .pad_o(pad), .swd_dio_i(swd_dio_o), .swd_dio_oe_i(swd_dio_oe_o), .gpio_dio_i(gpio_dio_o),
    .gpio_dio_oe_i(gpio_dio_oe_o), .pullup_i(pullup_o[1]), .pulldn_i(pulldn_o[1]));

  // 40 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // port configuration word from the two pin groups
  function automatic dbl_pkg::dbl_word_t cfg_word(input logic [4:0] c, input logic [4:0] d);
    return {19'h0, d, 3'h0, c};
  endfunction : cfg_word

  // expected run enables: watchdog stops in halt, timers follow the freeze mask
  function automatic dbl_pkg::dbl_word_t run_word(input logic halt, input logic [1:0] m);
    return {29'h0, !halt, halt ? ~m : 2'b11};
  endfunction : run_word

  // one value compare
  task automatic chk(input dbl_pkg::dbl_word_t got, input dbl_pkg::dbl_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // classic single wishbone cycle; held until ack, read data taken at that edge
  task automatic wb(input logic wr, input logic [7:0] a, input dbl_pkg::dbl_word_t d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= d;
    // no cycle count assumed: only the watchdog ends a wait that never gets its ack
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  // pin reset pulse; the enable pin flips afterwards and must be ignored
  task automatic pin_rst(input logic en_n);
    @(posedge clk_i);
    debug_enable_pin_n_i <= en_n;
    pin_reset_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    pin_reset_n_i <= 1'b1;
    repeat (14) @(posedge clk_i);
    debug_enable_pin_n_i <= !en_n;
    repeat (8) @(posedge clk_i);
  endtask : pin_rst

  // verdict and end of run
  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  // hang guard, well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    final_report();
  end

  // main sequence
  initial begin
    void'($urandom(32'h2393));
    {cyc_i, stb_i, we_i, core_halt_i, adr_i, dat_i} = '0;
    {rst_i, ce_i, pin_reset_n_i, debug_enable_pin_n_i} = 4'hF;
    sel_i = 4'hF;
    mismatches = 0;
    cmp_count = 0;
    // link domain needs its clock during reset
    fork
      repeat (4) @(posedge clk_i);
      dbl_probe_inst.frame(4, 1'b0, 32'h0);
    join
    rst_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk({26'h0, clk_sel, dio_sel, pullup_o, pulldn_o}, 32'h39);
    wb(1'b0, `DBL_OFS_PORT_CFG, 32'h0);
    chk(rd, cfg_word(`DBL_CLK_CFG_RST, `DBL_DIO_CFG_RST));
    wb(1'b0, `DBL_OFS_MONITOR, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0); // unmapped reads zero
    // unlocked: pins handed to the port leave the probe without control
    wb(1'b1, `DBL_OFS_PORT_CFG, cfg_word(5'h16, 5'h0E));
    repeat (3) @(posedge clk_i);
    chk({30'h0, clk_sel, dio_sel}, 32'h0);
    // both pins now port outputs: random data drives them and comes back on the data pad
    bits = $urandom;
    wb(1'b1, `DBL_OFS_GPIO, bits);
    repeat (6) @(posedge clk_i);
    chk({28'h0, gpio_clk_oe_o, gpio_dio_oe_o, gpio_clk_o, gpio_dio_o},
      {28'h0, 2'b11, bits[0], bits[1]});
    wb(1'b0, `DBL_OFS_GPIO, 32'h0);
    chk(rd, {22'h0, bits[1], 7'h0, bits[1:0]});
    dbl_probe_inst.frame(8, 1'b1, $urandom);
    chk({31'h0, swd_dio_oe_o}, 32'h0);
    wb(1'b1, `DBL_OFS_PORT_CFG, cfg_word(`DBL_CLK_CFG_RST, `DBL_DIO_CFG_RST));
    // routed again: traffic in both directions, last bit stands after the frame
    bits = $urandom;
    dbl_probe_inst.frame(8, 1'b1, bits);
    chk({30'h0, swd_dio_oe_o, swd_dio_o}, {30'h0, 1'b1, bits[7]});
    dbl_probe_inst.frame(8, 1'b0, bits >> 8);
    chk({31'h0, swd_dio_in_o}, {31'h0, bits[15]});
    repeat (10) @(posedge clk_i);
    wb(1'b0, `DBL_OFS_STATUS, 32'h0);
    chk(rd, 32'h1); // link activity seen
    wb(1'b1, `DBL_OFS_STATUS, 32'h1);
    wb(1'b0, `DBL_OFS_STATUS, 32'h0);
    chk(rd, 32'h0); // activity cleared by write of one
    // low enable at pin reset release locks the pins
    pin_rst(1'b0);
    wb(1'b0, `DBL_OFS_MONITOR, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, lock_o}, 32'h1);
    wb(1'b1, `DBL_OFS_PORT_CFG, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({26'h0, clk_sel, dio_sel, pullup_o, pulldn_o}, 32'h39);
    wb(1'b0, `DBL_OFS_PORT_CFG, 32'h0);
    chk(rd, cfg_word(`DBL_CLK_CFG_RST, `DBL_DIO_CFG_RST));
    wb(1'b1, `DBL_OFS_MONITOR, $urandom);
    wb(1'b0, `DBL_OFS_MONITOR, 32'h0);
    chk(rd, 32'h1);
    // high enable at the next pin reset clears the lock
    pin_rst(1'b1);
    wb(1'b0, `DBL_OFS_MONITOR, 32'h0);
    chk(rd, 32'h0);
    // halt with every freeze mask
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, `DBL_OFS_HALT_CFG, 32'(m) | ($urandom & 32'hFFFF_FFFC));
      core_halt_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({29'h0, wdt_run_o, timer_run_o}, run_word(1'b1, m[1:0]));
      chk({31'h0, periph_run_o}, 32'h1);
      wb(1'b0, `DBL_OFS_STATUS, 32'h0);
      chk(rd, 32'h2); // halt shows in status
      core_halt_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk({29'h0, wdt_run_o, timer_run_o}, run_word(1'b0, m[1:0]));
    end
    // clock enable low freezes the run enables although the core halts
    ce_i <= 1'b0;
    core_halt_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({31'h0, wdt_run_o}, 32'h1);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, wdt_run_o}, 32'h0);
    core_halt_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    final_report();
  end
endmodule : test_debug_enable_pin_lock
`default_nettype wire

// *** rtl/dbl_lock.sv ***
// debug enable pin lock, debug pin multiplexer and halt gating
//
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dbl_params.svh"

module dbl_lock #(
  parameter int NUM_TIMERS = 2,
  parameter int ADDR_W = 8
) (
  // system clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // external pins
  input wire logic pin_reset_n_i,
  input wire logic debug_enable_pin_n_i,
  // link side, clocked by the probe clock
  input wire logic swclk_i,
  input wire logic pad_dio_i,
  input wire logic swd_dio_out_i,
  input wire logic swd_dio_oe_i,
  output logic swd_dio_o,
  output logic swd_dio_oe_o,
  output logic swd_dio_in_o,
  // pin multiplexer, port side
  output logic clk_debug_sel_o,
  output logic dio_debug_sel_o,
  output logic gpio_clk_o,
  output logic gpio_clk_oe_o,
  output logic gpio_dio_o,
  output logic gpio_dio_oe_o,
  output logic [1:0] pullup_o,
  output logic [1:0] pulldn_o,
  // halt handling
  input wire logic core_halt_i,
  output logic wdt_run_o,
  output logic [NUM_TIMERS-1:0] timer_run_o,
  output logic periph_run_o,
  // lock flag for other logic
  output logic debug_lock_status_o
);

  // parameter sanity, refused at elaboration
  if (NUM_TIMERS < 1 || NUM_TIMERS > 8) begin : g_bad_timers
    $error("dbl_lock: NUM_TIMERS must be 1 to 8");
  end
  if (ADDR_W < 8) begin : g_bad_addr
    $error("dbl_lock: ADDR_W must be at least 8");
  end

  // ---------------- input synchronisers ----------------
  logic [`DBL_SY_N-1:0] sy1_r; // first stage, read only by second
  logic [`DBL_SY_N-1:0] sy2_r; // second stage
  logic [`DBL_SY_N-1:0] sy3_r; // third stage
  logic [`DBL_SY_N-1:0] filt_r; // accepted level
  logic [`DBL_SY_N-1:0] filt_prev_r; // accepted level one cycle ago
  logic act_tgl_r; // link activity toggle, link domain
  logic [`DBL_SY_N-1:0] sy_raw; // raw inputs per lane

  assign sy_raw[`DBL_SY_NRST] = pin_reset_n_i;
  assign sy_raw[`DBL_SY_DEBUG_ENABLE_PIN] = debug_enable_pin_n_i;
  assign sy_raw[`DBL_SY_DIO] = pad_dio_i;
  assign sy_raw[`DBL_SY_ACT] = act_tgl_r;

  // three flops per lane; a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < `DBL_SY_N; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          // pin reset starts asserted so the release after rst_i samples the enable pin
          sy1_r[g] <= 1'b0;
          sy2_r[g] <= 1'b0;
          sy3_r[g] <= 1'b0;
          filt_r[g] <= 1'b0;
          filt_prev_r[g] <= 1'b0;
        end else if (ce_i) begin
          sy1_r[g] <= sy_raw[g];
          sy2_r[g] <= sy1_r[g];
          sy3_r[g] <= sy2_r[g];
          if (sy2_r[g] == sy3_r[g]) begin
            filt_r[g] <= sy3_r[g];
          end
          filt_prev_r[g] <= filt_r[g];
        end
      end
    end
  endgenerate

  // events derived from the accepted levels
  logic pin_rst_rise; // pin reset released this cycle
  logic pin_rst_held; // pin reset currently asserted
  logic act_event; // one probe clock edge seen on the link
  assign pin_rst_rise = filt_r[`DBL_SY_NRST] & ~filt_prev_r[`DBL_SY_NRST];
  assign pin_rst_held = ~filt_r[`DBL_SY_NRST];
  assign act_event = filt_r[`DBL_SY_ACT] ^ filt_prev_r[`DBL_SY_ACT];

  // ---------------- debug enable lock ----------------
  logic lock_r; // debug pins locked to debug function

  // lock flag: cleared while pin reset is held, sampled at its release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_r <= 1'b0;
    end else if (ce_i) begin
      if (pin_rst_held) begin
        lock_r <= 1'b0;
      end else if (pin_rst_rise) begin
        lock_r <= ~filt_r[`DBL_SY_DEBUG_ENABLE_PIN];
      end
      // otherwise the flag holds, whatever the enable pin does later
    end
  end

  // ---------------- wishbone slave ----------------
  dbl_pkg::dbl_bus_t bus_r; // answer state
  logic [31:0] port_cfg_r; // pin settings of both debug pins
  logic [1:0] gpio_out_r; // port output data, bit 0 clock pin, bit 1 data pin
  logic [NUM_TIMERS-1:0] freeze_r; // timer freezes during halt when set
  logic activity_r; // sticky: probe clocked the link
  logic req; // request waiting for an answer
  logic wr_stb; // write takes effect this cycle
  logic [7:0] adr8; // decoded low address byte
  dbl_pkg::dbl_word_t rd_word; // read mux output

  assign adr8 = adr_i[7:0];
  assign req = cyc_i & stb_i & (bus_r == dbl_pkg::DBL_BUS_IDLE);
  assign wr_stb = ce_i & req & we_i;

  // answer one cycle after the request, drop ack the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_r <= dbl_pkg::DBL_BUS_IDLE;
      ack_o <= 1'b0;
    end else if (ce_i) begin
      case (bus_r)
        dbl_pkg::DBL_BUS_IDLE: begin
          ack_o <= req;
          if (req) begin
            bus_r <= dbl_pkg::DBL_BUS_ACK;
          end
        end
        dbl_pkg::DBL_BUS_ACK: begin
          ack_o <= 1'b0;
          bus_r <= dbl_pkg::DBL_BUS_IDLE;
        end
        default: begin
          ack_o <= 1'b0;
          bus_r <= dbl_pkg::DBL_BUS_IDLE;
        end
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_word = '0;
    case (adr8)
      `DBL_OFS_PORT_CFG: rd_word = port_cfg_r;
      `DBL_OFS_GPIO: begin
        rd_word[1:0] = gpio_out_r;
        rd_word[`DBL_GPIO_IN_LSB+1] =
          filt_r[`DBL_SY_DIO] & port_cfg_r[`DBL_DIO_LSB+`DBL_FLD_INEN];
      end
      `DBL_OFS_HALT_CFG: rd_word[NUM_TIMERS-1:0] = freeze_r;
      `DBL_OFS_STATUS: begin
        rd_word[`DBL_ST_ACTIVITY] = activity_r;
        rd_word[`DBL_ST_HALT] = core_halt_i;
        rd_word[`DBL_ST_PIN_RST] = pin_rst_held;
      end
      `DBL_OFS_MONITOR: rd_word[0] = lock_r;
      default: rd_word = '0;
    endcase
  end

  // read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (ce_i) begin
      if (req && !we_i) begin
        dat_o <= rd_word;
      end
    end
  end

  // pin settings; frozen while the lock is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_cfg_r <= '0;
      port_cfg_r[`DBL_CLK_LSB +: `DBL_PIN_FLD_W] <= `DBL_CLK_CFG_RST;
      port_cfg_r[`DBL_DIO_LSB +: `DBL_PIN_FLD_W] <= `DBL_DIO_CFG_RST;
    end else if (wr_stb && adr8 == `DBL_OFS_PORT_CFG && !lock_r) begin
      if (sel_i[0]) begin
        port_cfg_r[`DBL_CLK_LSB +: `DBL_PIN_FLD_W] <= dat_i[`DBL_CLK_LSB +: `DBL_PIN_FLD_W];
      end
      if (sel_i[1]) begin
        port_cfg_r[`DBL_DIO_LSB +: `DBL_PIN_FLD_W] <= dat_i[`DBL_DIO_LSB +: `DBL_PIN_FLD_W];
      end
    end
  end

  // port output data and timer freeze choices
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_out_r <= '0;
      freeze_r <= '0;
    end else if (wr_stb && sel_i[0]) begin
      if (adr8 == `DBL_OFS_GPIO) begin
        gpio_out_r <= dat_i[1:0];
      end
      if (adr8 == `DBL_OFS_HALT_CFG) begin
        freeze_r <= dat_i[NUM_TIMERS-1:0];
      end
    end
  end

  // link activity flag: write one clears, a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      activity_r <= 1'b0;
    end else if (ce_i) begin
      if (act_event) begin
        activity_r <= 1'b1;
      end else if (wr_stb && sel_i[0] && adr8 == `DBL_OFS_STATUS && dat_i[`DBL_ST_ACTIVITY]) begin
        activity_r <= 1'b0;
      end
    end
  end

  // ---------------- pin multiplexer ----------------
  logic clk_dbg; // clock pin in debug function
  logic dio_dbg; // data pin in debug function
  // port setting takes pin from debug unless the lock is set
  assign clk_dbg = lock_r | port_cfg_r[`DBL_CLK_LSB+`DBL_FLD_FUNC];
  assign dio_dbg = lock_r | port_cfg_r[`DBL_DIO_LSB+`DBL_FLD_FUNC];

  // registered multiplexer outputs; a locked pin is forced to the debug settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // reset leaves pins in debug use
      clk_debug_sel_o <= 1'b1;
      dio_debug_sel_o <= 1'b1;
      gpio_clk_o <= 1'b0;
      gpio_clk_oe_o <= 1'b0;
      gpio_dio_o <= 1'b0;
      gpio_dio_oe_o <= 1'b0;
      pullup_o <= 2'h2;
      pulldn_o <= 2'h1;
      debug_lock_status_o <= 1'b0;
    end else if (ce_i) begin
      clk_debug_sel_o <= clk_dbg;
      dio_debug_sel_o <= dio_dbg;
      gpio_clk_o <= gpio_out_r[0];
      gpio_clk_oe_o <= ~clk_dbg & port_cfg_r[`DBL_CLK_LSB+`DBL_FLD_OUTEN];
      gpio_dio_o <= gpio_out_r[1];
      gpio_dio_oe_o <= ~dio_dbg & port_cfg_r[`DBL_DIO_LSB+`DBL_FLD_OUTEN];
      pullup_o <= lock_r ? 2'h2 : {port_cfg_r[`DBL_DIO_LSB+`DBL_FLD_PULLUP],
                                    port_cfg_r[`DBL_CLK_LSB+`DBL_FLD_PULLUP]};
      pulldn_o <= lock_r ? 2'h1 : {port_cfg_r[`DBL_DIO_LSB+`DBL_FLD_PULLDN],
                                    port_cfg_r[`DBL_CLK_LSB+`DBL_FLD_PULLDN]};
      debug_lock_status_o <= lock_r;
    end
  end

  // ---------------- halt gating ----------------
  // run enables registered; the halt input comes from the same clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_run_o <= 1'b1;
      timer_run_o <= '1;
      periph_run_o <= 1'b1;
    end else if (ce_i) begin
      wdt_run_o <= ~core_halt_i;
      timer_run_o <= ~({NUM_TIMERS{core_halt_i}} & freeze_r);
      periph_run_o <= 1'b1;
    end
  end

  // ---------------- link domain ----------------
  logic lrst1_r; // reset crossing, first stage
  logic lrst_r; // link domain reset
  logic route1_r; // debug routing crossing, first stage
  logic route_r; // data pin routed to the probe

  // level crossings into the probe clock; the probe clock may stop between frames
  always_ff @(posedge swclk_i) begin
    lrst1_r <= rst_i;
    lrst_r <= lrst1_r;
    route1_r <= dio_debug_sel_o;
    route_r <= route1_r;
  end

  // probe drives and reads the pin only while routed
  always_ff @(posedge swclk_i) begin
    if (lrst_r) begin
      swd_dio_o <= 1'b0;
      swd_dio_oe_o <= 1'b0;
      swd_dio_in_o <= 1'b0;
      act_tgl_r <= 1'b0;
    end else if (route_r) begin
      swd_dio_o <= swd_dio_out_i;
      swd_dio_oe_o <= swd_dio_oe_i;
      swd_dio_in_o <= pad_dio_i;
      act_tgl_r <= ~act_tgl_r;
    end else begin
      swd_dio_oe_o <= 1'b0;
    end
  end

  // ---------------- assertions ----------------
  sequence pin_release_low_s;
    ce_i && pin_rst_rise && !filt_r[`DBL_SY_DEBUG_ENABLE_PIN];
  endsequence
  sequence mon_read_s;
    ce_i && req && !we_i && adr8 == `DBL_OFS_MONITOR;
  endsequence
  lock_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_release_low_s |=> lock_r ##1 (debug_lock_status_o || !ce_i))
    else $error("lock not set after low enable sample");
  lock_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_r && !pin_rst_held |=> lock_r)
    else $error("lock dropped without pin reset");
  lock_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && pin_rst_held |=> !lock_r)
    else $error("lock survived pin reset");
  mon_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mon_read_s |=> ack_o && dat_o == {31'h0, $past(lock_r)})
    else $error("monitor read value wrong");
  cfg_locked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_r |=> $stable(port_cfg_r))
    else $error("pin settings changed under lock");
  port_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !lock_r && !port_cfg_r[`DBL_DIO_LSB+`DBL_FLD_FUNC] |=> !dio_debug_sel_o)
    else $error("data pin still routed to debug");
  wdt_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && core_halt_i |=> !wdt_run_o && periph_run_o)
    else $error("watchdog ran during halt");
  timer_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && core_halt_i |=> timer_run_o == ~$past(freeze_r))
    else $error("timer run enable wrong during halt");
  periph_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> periph_run_o)
    else $error("peripherals stopped");
  reset_dflt_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> clk_debug_sel_o && dio_debug_sel_o && !debug_lock_status_o)
    else $error("debug pins not in debug use after reset");
endmodule : dbl_lock
`default_nettype wire

// *** rtl/dbl_params.svh ***
// constants of the debug enable pin lock: offsets, fields, reset values
`ifndef DBL_PARAMS_SVH
`define DBL_PARAMS_SVH

// register byte offsets
`define DBL_OFS_PORT_CFG 8'h00
`define DBL_OFS_GPIO 8'h04
`define DBL_OFS_HALT_CFG 8'h08
`define DBL_OFS_STATUS 8'h0C
`define DBL_OFS_MONITOR 8'h5C

// per-pin setting field positions inside a five bit group
`define DBL_FLD_FUNC 0
`define DBL_FLD_INEN 1
`define DBL_FLD_OUTEN 2
`define DBL_FLD_PULLUP 3
`define DBL_FLD_PULLDN 4
`define DBL_PIN_FLD_W 5

// pin groups inside the port configuration word
`define DBL_CLK_LSB 0
`define DBL_DIO_LSB 8

// reset values of the pin groups
`define DBL_CLK_CFG_RST 5'h13
`define DBL_DIO_CFG_RST 5'h0F

// status bits
`define DBL_ST_ACTIVITY 0
`define DBL_ST_HALT 1
`define DBL_ST_PIN_RST 2

// gpio word fields
`define DBL_GPIO_IN_LSB 8

// synchroniser lanes
`define DBL_SY_NRST 0
`define DBL_SY_DEBUG_ENABLE_PIN 1
`define DBL_SY_DIO 2
`define DBL_SY_ACT 3
`define DBL_SY_N 4

`endif

// *** rtl/dbl_pkg.sv ***
// types of the debug enable pin lock
package dbl_pkg;
  // bus slave answer state
  typedef enum logic {
    DBL_BUS_IDLE,
    DBL_BUS_ACK
  } dbl_bus_t;
  // one bus word
  typedef logic [31:0] dbl_word_t;
  // one pin's five settings
  typedef logic [4:0] dbl_pin_cfg_t;
endpackage : dbl_pkg
